// ===== pkg/gpq_defs.svh
/*
  Constants of the graphics port request queuing block: queue depth,
  clock rate and the statistics window.
  Assumes inclusion by bare name from the core and master model files.
*/
`ifndef GPQ_DEFS_SVH
`define GPQ_DEFS_SVH
`define GPQ_QDEPTH 8
`define GPQ_CLK_MHZ 200
`define GPQ_BW_WINDOW_MS 10
`define GPQ_BW_WINDOW_CYC (`GPQ_BW_WINDOW_MS * 1000 * `GPQ_CLK_MHZ)
`define GPQ_LAT_SYNC 16'h0002
`define GPQ_LAT_INIT 16'h0000
`endif

// ===== pkg/gpq_pkg.sv
/*
  Types of the graphics port request queuing block.
  Assumes a single 32-bit address and data path.
*/
`default_nettype none
package gpq_pkg;
  typedef struct packed {
    logic write;
    logic high;
    logic [31:0] addr;
  } gpq_req_t;

  typedef struct packed {
    logic req_valid;
    gpq_req_t req;
    logic wr_valid;
    logic [31:0] wr_data;
    logic pci_valid;
    logic pci_write;
    logic [31:0] pci_addr;
    logic [31:0] pci_wdata;
    logic tgt_done;
    logic [31:0] tgt_rdata;
  } gpq_pin_t;

  typedef struct packed {
    logic rd_valid;
    logic [31:0] rd_data;
    logic wr_call;
    logic tgt_start;
    logic tgt_write;
    logic [31:0] tgt_addr;
    logic [31:0] tgt_wdata;
    logic pci_done;
    logic [31:0] pci_rdata;
  } gpq_xfer_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gpq_mem_t;

  typedef enum logic [6:0] {
    GPQ_IDLE = 7'b0000001,
    GPQ_RMEM = 7'b0000010,
    GPQ_WCALL = 7'b0000100,
    GPQ_WMEM = 7'b0001000,
    GPQ_SNOOP = 7'b0010000,
    GPQ_PMEM = 7'b0100000,
    GPQ_CPU = 7'b1000000
  } gpq_state_t;
endpackage
`default_nettype wire

// ===== rtl/gpq_core.sv
/*
  Corelogic side of a graphics port: split-transaction request queues,
  read return, write data calls, conventional transaction queues.
  Assumes one clock; master pins pass a two-flop synchroniser; memory,
  snoop and processor ports are on clk_sys.
*/
// Contract
// [RULE1] Corelogic reaches master only by conventional transactions
// [RULE2] Split requests, data and conventional traffic interleave
// [RULE3] Request phase separate from data phase
// [RULE4] Corelogic alone starts each data transfer
// [RULE5] Master may pipeline several outstanding requests
// [RULE6] High and low priority sub-queues
// [RULE7] Master models queue to limit requests
// [RULE8] Reads fetched from memory, returned when ready
// [RULE9] Write data called only with buffer room
// [RULE10] Conventional transactions use separate queues
// [RULE11] Processor accesses queued, issued non-pipelined
// [RULE12] One master, one target active
// [RULE13] Other attached devices stay silent
// [RULE14] Conventional transactions snooped for coherency
// [RULE15] Completed data agrees with cache copies
// [RULE16] Master expects no snooping of split requests
// [RULE17] Publish worst high priority latency
// [RULE18] Publish low priority bandwidth over frame
// [RULE19] Split requests carry no coherency
// [RULE20] High priority served before low priority
`timescale 1ns/10ps
`default_nettype none
`include "gpq_defs.svh"
module gpq_core #(
  parameter int QDEPTH = `GPQ_QDEPTH,
  parameter int BW_WINDOW = `GPQ_BW_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Graphics master pins
  input wire gpq_pkg::gpq_pin_t pin_in,
  output var gpq_pkg::gpq_xfer_t xfer_out,
  // Processor access to the master's target
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_busy,
  output logic cpu_done,
  output logic [31:0] cpu_rdata,
  // System memory
  output var gpq_pkg::gpq_mem_t mem_req,
  input wire logic mem_done,
  input wire logic [31:0] mem_rdata,
  // Processor cache snoop
  output logic snoop_req,
  output logic [31:0] snoop_addr,
  input wire logic snoop_done,
  // Performance figures
  output logic [15:0] hi_lat_max,
  output logic [31:0] lo_bw_words
);
  localparam int PW = $clog2(QDEPTH);
  localparam logic [PW:0] QFULL = (PW + 1)'(QDEPTH);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(QDEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  gpq_pkg::gpq_pin_t pin_m, pin_s;
  gpq_pkg::gpq_state_t st, next_st;
  gpq_pkg::gpq_req_t hq [QDEPTH];
  gpq_pkg::gpq_req_t lq [QDEPTH];
  gpq_pkg::gpq_req_t cur, next_cur;
  logic [PW-1:0] hh, ht, lh, lt;
  logic [PW:0] hq_n, lq_n;
  logic hpush, lpush, hpop, lpop, take_pci, take_cpu, cur_hi;
  logic wbuf_full, pci_q_v, pci_q_w, cpu_q_w, lat_run, pci_prev;
  logic [31:0] pci_q_a, pci_q_d, cpu_q_a, cpu_q_d, win_cnt, bw_cnt;
  logic [15:0] lat_cnt;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_m <= '0;
      pin_s <= '0;
    end else begin
      pin_m <= pin_in; // [RULE12]
      pin_s <= pin_m;
    end
  end

  // Requests are only queued here; data moves later on our own initiative.
  assign hpush = pin_s.req_valid && pin_s.req.high && hq_n != QFULL; // [RULE3] [RULE6]
  assign lpush = pin_s.req_valid && !pin_s.req.high && lq_n != QFULL; // [RULE5] [RULE6]

  always_comb begin
    hpop = 1'b0;
    lpop = 1'b0;
    take_pci = 1'b0;
    take_cpu = 1'b0;
    if (st == gpq_pkg::GPQ_IDLE) begin // [RULE2]
      if (hq_n != '0 && (!hq[hh].write || !wbuf_full)) begin // [RULE20]
        hpop = 1'b1;
      end else if (pci_q_v) begin // [RULE10]
        take_pci = 1'b1;
      end else if (cpu_busy) begin // [RULE11]
        take_cpu = 1'b1;
      end else if (lq_n != '0 && (!lq[lh].write || !wbuf_full)) begin
        lpop = 1'b1;
      end
    end
  end

  always_comb begin
    next_cur = hpop ? hq[hh] : lq[lh];
    next_st = st;
    unique case (st)
      gpq_pkg::GPQ_IDLE: begin
        if (hpop || lpop) begin
          next_st = next_cur.write ? gpq_pkg::GPQ_WCALL : gpq_pkg::GPQ_RMEM; // [RULE4]
        end else if (take_pci) begin
          next_st = gpq_pkg::GPQ_SNOOP; // [RULE14]
        end else if (take_cpu) begin
          next_st = gpq_pkg::GPQ_CPU;
        end
      end
      gpq_pkg::GPQ_RMEM: if (mem_done) next_st = gpq_pkg::GPQ_IDLE;
      gpq_pkg::GPQ_WCALL: if (pin_s.wr_valid) next_st = gpq_pkg::GPQ_WMEM;
      gpq_pkg::GPQ_WMEM: if (mem_done) next_st = gpq_pkg::GPQ_IDLE;
      gpq_pkg::GPQ_SNOOP: if (snoop_done) next_st = gpq_pkg::GPQ_PMEM; // [RULE15]
      gpq_pkg::GPQ_PMEM: if (mem_done) next_st = gpq_pkg::GPQ_IDLE;
      gpq_pkg::GPQ_CPU: if (pin_s.tgt_done) next_st = gpq_pkg::GPQ_IDLE;
      default: next_st = gpq_pkg::GPQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= gpq_pkg::GPQ_IDLE;
      cur <= '0;
      cur_hi <= 1'b0;
    end else begin
      st <= next_st;
      if (hpop || lpop) begin
        cur <= next_cur;
        cur_hi <= hpop;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hh <= '0;
      ht <= '0;
      hq_n <= '0;
    end else begin
      if (hpush) begin
        hq[ht] <= pin_s.req;
        ht <= ptr_inc(ht);
      end
      if (hpop) hh <= ptr_inc(hh);
      hq_n <= hq_n + (PW + 1)'(hpush) - (PW + 1)'(hpop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lh <= '0;
      lt <= '0;
      lq_n <= '0;
    end else begin
      if (lpush) begin
        lq[lt] <= pin_s.req;
        lt <= ptr_inc(lt);
      end
      if (lpop) lh <= ptr_inc(lh);
      lq_n <= lq_n + (PW + 1)'(lpush) - (PW + 1)'(lpop);
    end
  end

  // The master answers a conventional transaction only after completion,
  // so one entry shared by reads and writes is enough. The synchroniser delays the fall
  // of pci_valid after pci_done, so only its rising edge starts a new entry.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pci_prev <= 1'b0;
      pci_q_v <= 1'b0;
      pci_q_w <= 1'b0;
      pci_q_a <= '0;
      pci_q_d <= '0;
    end else begin
      pci_prev <= pin_s.pci_valid;
      if (!pci_q_v && pin_s.pci_valid && !pci_prev) begin // [RULE10]
        pci_q_v <= 1'b1;
        pci_q_w <= pin_s.pci_write;
        pci_q_a <= pin_s.pci_addr;
        pci_q_d <= pin_s.pci_wdata;
      end else if (st == gpq_pkg::GPQ_PMEM && mem_done) begin
        pci_q_v <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_busy <= 1'b0;
      cpu_q_w <= 1'b0;
      cpu_q_a <= '0;
      cpu_q_d <= '0;
    end else if (!cpu_busy && cpu_valid) begin // [RULE11]
      cpu_busy <= 1'b1;
      cpu_q_w <= cpu_write;
      cpu_q_a <= cpu_addr;
      cpu_q_d <= cpu_wdata;
    end else if (st == gpq_pkg::GPQ_CPU && pin_s.tgt_done) begin
      cpu_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wbuf_full <= 1'b0;
      mem_req <= '0;
    end else if (mem_done) begin
      mem_req.valid <= 1'b0;
      if (st == gpq_pkg::GPQ_WMEM) wbuf_full <= 1'b0;
    end else if (st == gpq_pkg::GPQ_WCALL && pin_s.wr_valid) begin // [RULE9]
      wbuf_full <= 1'b1;
      mem_req <= '{valid: 1'b1, write: 1'b1, addr: cur.addr, wdata: pin_s.wr_data};
    end else if ((hpop || lpop) && !next_cur.write) begin // [RULE8] [RULE19]
      mem_req <= '{valid: 1'b1, write: 1'b0, addr: next_cur.addr, wdata: 32'h00000000};
    end else if (st == gpq_pkg::GPQ_SNOOP && snoop_done) begin // [RULE15]
      mem_req <= '{valid: 1'b1, write: pci_q_w, addr: pci_q_a, wdata: pci_q_d};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xfer_out <= '0;
      cpu_done <= 1'b0;
      cpu_rdata <= '0;
      snoop_req <= 1'b0;
      snoop_addr <= '0;
    end else begin
      xfer_out.rd_valid <= st == gpq_pkg::GPQ_RMEM && mem_done; // [RULE4] [RULE8]
      if (st == gpq_pkg::GPQ_RMEM && mem_done) xfer_out.rd_data <= mem_rdata;
      xfer_out.wr_call <= next_st == gpq_pkg::GPQ_WCALL; // [RULE9]
      xfer_out.tgt_start <= take_cpu; // [RULE1]
      if (take_cpu) begin
        xfer_out.tgt_write <= cpu_q_w;
        xfer_out.tgt_addr <= cpu_q_a;
        xfer_out.tgt_wdata <= cpu_q_d;
      end
      xfer_out.pci_done <= st == gpq_pkg::GPQ_PMEM && mem_done; // [RULE14]
      if (st == gpq_pkg::GPQ_PMEM && mem_done) xfer_out.pci_rdata <= mem_rdata;
      cpu_done <= st == gpq_pkg::GPQ_CPU && pin_s.tgt_done;
      if (st == gpq_pkg::GPQ_CPU && pin_s.tgt_done) cpu_rdata <= pin_s.tgt_rdata;
      snoop_req <= next_st == gpq_pkg::GPQ_SNOOP; // [RULE14]
      if (take_pci) snoop_addr <= pci_q_a;
    end
  end

  // Latency is timed only from an empty pipeline; the synchroniser delay
  // is added back so the figure starts at the master's request clock.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lat_run <= 1'b0;
      lat_cnt <= `GPQ_LAT_INIT;
      hi_lat_max <= `GPQ_LAT_INIT;
    end else if (!lat_run) begin
      if (hpush && !pin_s.req.write && hq_n == '0 && st == gpq_pkg::GPQ_IDLE) begin // [RULE17]
        lat_run <= 1'b1;
        lat_cnt <= `GPQ_LAT_SYNC;
      end
    end else if (xfer_out.rd_valid) begin
      lat_run <= 1'b0;
      if (lat_cnt > hi_lat_max) hi_lat_max <= lat_cnt;
    end else if (lat_cnt != 16'hFFFF) begin
      lat_cnt <= lat_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      win_cnt <= '0;
      bw_cnt <= '0;
      lo_bw_words <= '0;
    end else if (win_cnt == 32'(BW_WINDOW - 1)) begin // [RULE18]
      win_cnt <= '0;
      bw_cnt <= '0;
      lo_bw_words <= bw_cnt;
    end else begin
      win_cnt <= win_cnt + 32'h00000001;
      if (mem_done && !cur_hi && (st == gpq_pkg::GPQ_RMEM || st == gpq_pkg::GPQ_WMEM)) begin
        bw_cnt <= bw_cnt + 32'h00000001;
      end
    end
  end

  sequence s_rd_back;
    st == gpq_pkg::GPQ_RMEM && mem_done;
  endsequence
  sequence s_snoop_ok;
    st == gpq_pkg::GPQ_SNOOP && snoop_done;
  endsequence
  sequence s_pci_mem_ok;
    st == gpq_pkg::GPQ_PMEM && mem_done;
  endsequence

  a_read_return: assert property (@(posedge clk_sys) disable iff (reset) // [RULE8]
    s_rd_back |=> xfer_out.rd_valid && xfer_out.rd_data == $past(mem_rdata))
    else $error("read data not returned after memory answer");
  a_rd_own_init: assert property (@(posedge clk_sys) disable iff (reset) // [RULE4]
    xfer_out.rd_valid |-> $past(st) == gpq_pkg::GPQ_RMEM)
    else $error("read return without queued read");
  a_wr_call_room: assert property (@(posedge clk_sys) disable iff (reset) // [RULE9]
    xfer_out.wr_call |-> !wbuf_full && st == gpq_pkg::GPQ_WCALL)
    else $error("write data called without buffer room");
  a_hi_first: assert property (@(posedge clk_sys) disable iff (reset) // [RULE20]
    (st == gpq_pkg::GPQ_IDLE && hq_n != '0 && !hq[hh].write && lq_n != '0)
      |=> cur_hi && st == gpq_pkg::GPQ_RMEM)
    else $error("low priority served ahead of high priority");
  a_hq_push: assert property (@(posedge clk_sys) disable iff (reset) // [RULE6]
    (hpush && !hpop) |=> hq_n == $past(hq_n) + 1)
    else $error("high priority request not queued");
  a_snoop_first: assert property (@(posedge clk_sys) disable iff (reset) // [RULE15]
    s_snoop_ok |=> st == gpq_pkg::GPQ_PMEM && mem_req.valid && mem_req.addr == pci_q_a)
    else $error("memory access not issued after snoop");
  a_pci_done: assert property (@(posedge clk_sys) disable iff (reset) // [RULE14]
    s_pci_mem_ok |=> xfer_out.pci_done ##1 !xfer_out.pci_done)
    else $error("conventional completion not signalled once");
  a_cpu_single: assert property (@(posedge clk_sys) disable iff (reset) // [RULE11]
    xfer_out.tgt_start |=> (!xfer_out.tgt_start && st == gpq_pkg::GPQ_CPU) [*2])
    else $error("processor access pipelined to master");
endmodule
`default_nettype wire

// ===== testbench/gpq_mst.sv
/*
  Behavioural graphics master facing the corelogic request queues.
  Assumes the bench calls req, req_end and pci 1 ns after a clk_sys edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpq_defs.svh"
module gpq_mst (
  // Clock
  input wire logic clk_sys,
  // Corelogic side
  input wire gpq_pkg::gpq_xfer_t xfer,
  output var gpq_pkg::gpq_pin_t pins
);
  logic req_v = 0, wv = 0, pv = 0, pw = 0, td = 0, wc_q = 0;
  gpq_pkg::gpq_req_t rq = '0;
  logic [31:0] wd = '0, pa = '0, pd = '0, trd = '0, ta = '0, tw = '0;
  logic [31:0] wq[$];
  logic [31:0] rd_q[$];
  int n_out = 0, n_bad = 0, tgt_lat = 1, t_cnt = 0;
  assign pins = {req_v, rq, wv, wd, pv, pw, pa, pd, td, trd};
  task automatic req(input logic w, input logic h, input logic [31:0] a);
    if (n_out + wq.size() >= `GPQ_QDEPTH) n_bad++;
    rq = {w, h, a};
    req_v = 1'b1;
    if (w) wq.push_back(a);
    else n_out++;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic req_end();
    req_v = 1'b0;
    rq = ~rq;
  endtask
  // Holds the conventional request until completion, then releases the lines.
  task automatic pci(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    {pv, pw, pa, pd} = {1'b1, w, a, d};
    r = '0;
    for (int i = 0; i < 300 && pv; i++) begin
      @(posedge clk_sys);
      #1;
      if (xfer.pci_done) begin
        r = xfer.pci_rdata;
        {pv, pa, pd} = {1'b0, ~a, ~d};
      end
    end
    // Let the release pass the corelogic's synchroniser before a new request.
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    wc_q <= xfer.wr_call;
    wv <= 1'b0;
    td <= 1'b0;
    if (wv) wd <= ~wd;
    if (td) trd <= ~trd;
    // Write data only goes out when the corelogic calls for it.
    if (xfer.wr_call && !wc_q) begin
      if (wq.size() == 0) n_bad++;
      wv <= 1'b1;
      wd <= wq.pop_front() ^ 32'hC3C3_3C3C;
    end
    if (xfer.rd_valid) begin
      if (n_out == 0) n_bad++;
      else n_out--;
      rd_q.push_back(xfer.rd_data);
    end
    if (xfer.tgt_start) begin
      if (t_cnt > 0 || td) n_bad++;
      t_cnt <= tgt_lat;
      {ta, tw} <= {xfer.tgt_addr, xfer.tgt_wdata};
    end else if (t_cnt > 0) begin
      t_cnt <= t_cnt - 1;
      if (t_cnt == 1) begin
        td <= 1'b1;
        trd <= ta ^ 32'h0F0F_F0F0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/*
  Self-checking bench for the graphics port request queuing core.
  Assumes gpq_pkg and the master model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [31:0] MK = 32'h5A5A_0F0F;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cpu_valid = 0, cpu_write = 0, mem_done = 0, snoop_done = 0, cpu_busy, cpu_done, snoop_req;
  logic [31:0] cpu_addr = '0, cpu_wdata = '0, mem_rdata = '0, cpu_rdata, snoop_addr, lo_bw_words;
  logic [31:0] bw_max = '0, wr_addr = '0, wr_data = '0;
  logic [15:0] hi_lat_max;
  gpq_pkg::gpq_pin_t pin_in;
  gpq_pkg::gpq_xfer_t xfer_out;
  gpq_pkg::gpq_mem_t mem_req;
  int n_errors = 0, compares = 0, mem_lat = 2, m_cnt = 0, n_snoop = 0;
  gpq_core #(.QDEPTH(8), .BW_WINDOW(64)) gpq_core_i (.clk_sys, .reset, .pin_in, .xfer_out,
    .cpu_valid, .cpu_write, .cpu_addr, .cpu_wdata, .cpu_busy, .cpu_done, .cpu_rdata,
    .mem_req, .mem_done, .mem_rdata, .snoop_req, .snoop_addr, .snoop_done, .hi_lat_max,
    .lo_bw_words);
  // The master model is the only device on the port; nothing else drives it.
  gpq_mst gpq_mst_i (.clk_sys(clk_sys), .xfer(xfer_out), .pins(pin_in));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Memory answers after mem_lat cycles, snoops after one; read data is address based.
  always @(posedge clk_sys) begin
    mem_done <= 1'b0;
    mem_rdata <= ~mem_rdata;
    snoop_done <= snoop_req && !snoop_done;
    if (snoop_done) n_snoop++;
    if (lo_bw_words > bw_max) bw_max <= lo_bw_words;
    if (mem_req.valid && !mem_done) begin
      m_cnt <= m_cnt + 1;
      if (m_cnt + 1 >= mem_lat) begin
        m_cnt <= 0;
        mem_done <= 1'b1;
        mem_rdata <= mem_req.addr ^ MK;
        if (mem_req.write) {wr_addr, wr_data} <= {mem_req.addr, mem_req.wdata};
      end
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask
  task automatic give_up(input string msg);
    check(1'b0, msg);
    tally_and_finish();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_rd(input int n, output int t);
    for (t = 1; t < 300 && gpq_mst_i.rd_q.size() < n; t++) tick(1);
    if (t == 300) give_up("read return timed out");
  endtask
  task automatic s_read_hi();
    int t;
    gpq_mst_i.req(1'b0, 1'b1, 32'h0000_1000);
    gpq_mst_i.req_end();
    wait_rd(1, t);
    tick(2);
    check(gpq_mst_i.rd_q.pop_front() === (32'h0000_1000 ^ MK), "high read");
    check(hi_lat_max >= 16'h0002 && hi_lat_max <= 16'(t + 4), "latency figure");
    check(n_snoop == 0, "split read snooped");
  endtask
  task automatic s_pipeline();
    logic [31:0] e[3] = '{32'h0000_2000, 32'h0000_2200, 32'h0000_2100};
    int t;
    mem_lat = 8;
    gpq_mst_i.req(1'b0, 1'b0, e[0]);
    gpq_mst_i.req(1'b0, 1'b0, e[2]);
    gpq_mst_i.req(1'b0, 1'b1, e[1]);
    gpq_mst_i.req_end();
    wait_rd(3, t);
    foreach (e[i]) check(gpq_mst_i.rd_q.pop_front() === (e[i] ^ MK), "order");
  endtask
  task automatic s_write_mixed();
    int t;
    mem_lat = 2;
    gpq_mst_i.req(1'b1, 1'b0, 32'h0000_3000);
    gpq_mst_i.req(1'b0, 1'b1, 32'h0000_3100);
    gpq_mst_i.req_end();
    wait_rd(1, t);
    for (t = 0; t < 300 && wr_addr !== 32'h0000_3000; t++) tick(1);
    if (t == 300) give_up("write timed out");
    check(wr_data === (32'h0000_3000 ^ 32'hC3C3_3C3C), "write data");
    check(gpq_mst_i.rd_q.pop_front() === (32'h0000_3100 ^ MK), "read beside write");
  endtask
  task automatic s_pci();
    logic [31:0] r;
    int s0;
    s0 = n_snoop;
    mem_lat = 6;
    gpq_mst_i.req(1'b0, 1'b0, 32'h0000_4000);
    gpq_mst_i.req(1'b0, 1'b0, 32'h0000_4100);
    gpq_mst_i.req_end();
    gpq_mst_i.pci(1'b1, 32'h0000_5000, 32'h1234_ABCD, r);
    if (gpq_mst_i.pv) give_up("pci write timed out");
    check(wr_addr === 32'h0000_5000 && wr_data === 32'h1234_ABCD, "pci write");
    gpq_mst_i.pci(1'b0, 32'h0000_5100, 32'h0000_0000, r);
    if (gpq_mst_i.pv) give_up("pci read timed out");
    check(r === (32'h0000_5100 ^ MK), "pci read");
    check(n_snoop - s0 == 2, "pci snoop count");
    wait_rd(2, s0);
    check(gpq_mst_i.rd_q.pop_front() === (32'h0000_4000 ^ MK), "split read one");
    check(gpq_mst_i.rd_q.pop_front() === (32'h0000_4100 ^ MK), "split read two");
  endtask
  task automatic s_cpu();
    logic [31:0] a;
    int t;
    for (int i = 0; i < 2; i++) begin
      a = {28'h0000600, i[3:0]};
      gpq_mst_i.tgt_lat = (i == 0) ? 6 : 1;
      {cpu_valid, cpu_write, cpu_addr, cpu_wdata} = {1'b1, i[0], a, ~a};
      tick(1);
      cpu_valid = 1'b0;
      check(cpu_busy === 1'b1, "processor not busy");
      for (t = 0; t < 300 && cpu_done !== 1'b1; t++) tick(1);
      if (t == 300) give_up("processor access timed out");
      check(gpq_mst_i.ta === a && gpq_mst_i.tw === ~a && xfer_out.tgt_write === i[0],
        "target access");
      if (i == 0) check(cpu_rdata === (a ^ 32'h0F0F_F0F0), "processor read");
      tick(1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    check(xfer_out === '0 && mem_req === '0 && cpu_busy === 1'b0, "outputs busy in reset");
    reset = 1'b0;
    tick(2);
    s_read_hi();
    s_pipeline();
    s_write_mixed();
    s_pci();
    s_cpu();
    check(gpq_mst_i.n_bad == 0, "unsolicited transfer");
    check(bw_max >= 32'h1 && bw_max <= 32'h5, "low bandwidth figure");
    tally_and_finish();
  end
endmodule
`default_nettype wire
